//--- verilog/nonvolatile_byte_store.sv
// Non-volatile byte store: APB register front end, sequencer and byte array
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ns
module nonvolatile_byte_store #(
   parameter int unsigned WRITE_CYCLES = nonvolatile_byte_store_pkg::WRITE_CYCLES,
   parameter int unsigned MAINT_CYCLES = nonvolatile_byte_store_pkg::MAINT_CYCLES,
   parameter int unsigned READ_CYCLES = nonvolatile_byte_store_pkg::READ_CYCLES,
   parameter int unsigned STORE_SIZE = nonvolatile_byte_store_pkg::STORE_DEPTH
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Operation in progress
   output logic busy
);

   // ----------------------------------------------------------------------
   // State record
   // ----------------------------------------------------------------------
   typedef struct packed {
      nonvolatile_byte_store_pkg::op_state_t state;       // Sequencer state
      logic op_write;                   // Operation kind in flight
      logic [7:0] req_addr;             // Location address as written
      logic [7:0] req_data;             // Data byte as written
      logic [7:0] addr;                 // Address captured at start
      logic [7:0] wdata;                // Data captured at start
      logic [15:0] ratio;               // Ref cycles per system clock tick
      logic [15:0] div_cnt;             // Tick divider
      logic [31:0] timer;               // Ticks left in operation
      logic [7:0] result0;              // First working register image
      logic [7:0] result1;              // Second working register image
      logic done;                       // Sticky flag, set once the duration loads in the first busy cycle
      logic [31:0] wcount;              // Writes without address or flash error since reset
      logic [7:0] maint_cnt;            // Writes since last maintenance
      logic [1:0] fault;                // Fault injection controls
      logic [31:0] prdata;              // Read data for access phase
      logic pslverr;                    // Error for access phase
      logic [63:0][7:0] latest;         // Most recent byte per location
      logic [63:0][7:0] good;           // Most recent verified byte
      logic [63:0] corrupt;             // Latest copy failed verify
   } store_state_t;

   store_state_t cur;
   store_state_t next_cur;

   // Bus phase decodes
   logic setup_phase;
   logic access_write;
   logic tick;
   logic addr_legal;
   logic flash_bad;
   logic [5:0] idx;

   assign setup_phase = psel & ~penable;
   assign access_write = psel & penable & pwrite;
   // Zero wait states: data was latched in the setup cycle
   assign pready = 1'b1;
   assign prdata = cur.prdata;
   assign pslverr = cur.pslverr;
   assign busy = (cur.state == nonvolatile_byte_store_pkg::ST_BUSY);

   // ----------------------------------------------------------------------
   // Derived conditions
   // ----------------------------------------------------------------------
   // Timing runs on a divided tick so a slower system clock stretches it
   assign tick = (cur.ratio <= 16'h0001) || (cur.div_cnt == cur.ratio - 16'h0001);
   // Bytes beyond the configured size are illegal
   assign addr_legal = (32'(cur.addr) < STORE_SIZE);
   // An unset clock ratio leaves flash timing unsafe, so it counts as a fault
   assign flash_bad = (cur.ratio == 16'h0000) | cur.fault[nonvolatile_byte_store_pkg::FAULT_FLASH_BIT];
   assign idx = cur.addr[5:0];

   // ----------------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------------
   always_comb begin
      next_cur = cur;
      next_cur.pslverr = 1'b0;

      // Tick divider free-runs while an operation is in flight
      if (cur.state == nonvolatile_byte_store_pkg::ST_BUSY && !tick) begin
         next_cur.div_cnt = cur.div_cnt + 16'h0001;
      end else begin
         next_cur.div_cnt = 16'h0000;
      end

      // Register reads are captured in the setup cycle
      if (setup_phase && !pwrite) begin
         next_cur.prdata = 32'h0000_0000;
         case (paddr)
            nonvolatile_byte_store_pkg::REG_CTRL: begin
               next_cur.prdata = 32'h0000_0000;
            end
            nonvolatile_byte_store_pkg::REG_ADDR: begin
               next_cur.prdata = {24'h00_0000, cur.req_addr};
            end
            nonvolatile_byte_store_pkg::REG_WDATA: begin
               next_cur.prdata = {24'h00_0000, cur.req_data};
            end
            nonvolatile_byte_store_pkg::REG_STATUS: begin
               next_cur.prdata[nonvolatile_byte_store_pkg::STATUS_BUSY_BIT] = busy;
               next_cur.prdata[nonvolatile_byte_store_pkg::STATUS_DONE_BIT] = cur.done;
            end
            nonvolatile_byte_store_pkg::REG_RESULT0: begin
               next_cur.prdata = {24'h00_0000, cur.result0};
            end
            nonvolatile_byte_store_pkg::REG_RESULT1: begin
               next_cur.prdata = {24'h00_0000, cur.result1};
            end
            nonvolatile_byte_store_pkg::REG_RATIO: begin
               next_cur.prdata = {16'h0000, cur.ratio};
            end
            nonvolatile_byte_store_pkg::REG_WCOUNT: begin
               next_cur.prdata = cur.wcount;
            end
            nonvolatile_byte_store_pkg::REG_FAULT: begin
               next_cur.prdata = {30'h0000_0000, cur.fault};
            end
            default: begin
               next_cur.pslverr = 1'b1;
            end
         endcase
      end

      // Unmapped write addresses also answer with an error
      if (setup_phase && pwrite) begin
         case (paddr)
            nonvolatile_byte_store_pkg::REG_CTRL, nonvolatile_byte_store_pkg::REG_ADDR, nonvolatile_byte_store_pkg::REG_WDATA, nonvolatile_byte_store_pkg::REG_STATUS,
            nonvolatile_byte_store_pkg::REG_RESULT0, nonvolatile_byte_store_pkg::REG_RESULT1, nonvolatile_byte_store_pkg::REG_RATIO, nonvolatile_byte_store_pkg::REG_WCOUNT,
            nonvolatile_byte_store_pkg::REG_FAULT: begin
               next_cur.pslverr = 1'b0;
            end
            default: begin
               next_cur.pslverr = 1'b1;
            end
         endcase
      end

      // Register writes take effect in the access cycle
      if (access_write) begin
         case (paddr)
            nonvolatile_byte_store_pkg::REG_ADDR: begin
               next_cur.req_addr = pwdata[7:0];
            end
            nonvolatile_byte_store_pkg::REG_WDATA: begin
               next_cur.req_data = pwdata[7:0];
            end
            nonvolatile_byte_store_pkg::REG_RATIO: begin
               // Changing timing mid-operation would skew the count
               if (!busy) begin
                  next_cur.ratio = pwdata[15:0];
               end
            end
            nonvolatile_byte_store_pkg::REG_FAULT: begin
               next_cur.fault = pwdata[1:0];
            end
            nonvolatile_byte_store_pkg::REG_CTRL: begin
               // Starts while busy are dropped; the caller polls first
               if (!busy && (pwdata[nonvolatile_byte_store_pkg::CTRL_WRITE_BIT] || pwdata[nonvolatile_byte_store_pkg::CTRL_READ_BIT])) begin
                  next_cur.state = nonvolatile_byte_store_pkg::ST_BUSY;
                  next_cur.done = 1'b0;
                  next_cur.op_write = pwdata[nonvolatile_byte_store_pkg::CTRL_WRITE_BIT]; // Write wins if both set
                  next_cur.addr = cur.req_addr;
                  next_cur.wdata = cur.req_data;
                  next_cur.timer = 32'h0000_0000;
               end
            end
            default: begin
               next_cur.ratio = cur.ratio;
            end
         endcase
      end

      // Operation sequencer
      case (cur.state)
         nonvolatile_byte_store_pkg::ST_IDLE: begin
            next_cur.timer = next_cur.timer;
         end
         nonvolatile_byte_store_pkg::ST_BUSY: begin
            if (cur.timer == 32'h0000_0000 && cur.div_cnt == 16'h0000 && !cur.done) begin
               // First cycle: load the duration for this kind of operation
               if (cur.op_write) begin
                  if (!addr_legal) begin
                     next_cur.timer = nonvolatile_byte_store_pkg::ILL_WRITE_CYCLES;
                  end else if (cur.maint_cnt == nonvolatile_byte_store_pkg::MAINT_PERIOD - 8'h01) begin
                     next_cur.timer = 32'(WRITE_CYCLES + MAINT_CYCLES);
                  end else begin
                     next_cur.timer = 32'(WRITE_CYCLES);
                  end
               end else begin
                  if (!addr_legal) begin
                     next_cur.timer = nonvolatile_byte_store_pkg::ILL_READ_CYCLES;
                  end else begin
                     next_cur.timer = 32'(READ_CYCLES);
                  end
               end
               next_cur.done = 1'b1;
            end else if (tick && cur.timer > 32'h0000_0001) begin
               next_cur.timer = cur.timer - 32'h0000_0001;
            end else if (tick) begin
               // Last tick: all work finishes here, results appear with idle
               next_cur.timer = 32'h0000_0000;
               next_cur.state = nonvolatile_byte_store_pkg::ST_IDLE;
               next_cur.result0 = 8'h00;
               next_cur.result1 = 8'h00;
               if (cur.op_write) begin
                  // Status byte: only defined flag bits, zero on success
                  next_cur.result0[nonvolatile_byte_store_pkg::ILLEGAL_ADDR_BIT] = ~addr_legal;
                  next_cur.result0[nonvolatile_byte_store_pkg::FLASH_ERR_BIT] = flash_bad;
                  if (addr_legal && !flash_bad) begin
                     next_cur.latest[idx] = cur.wdata;
                     next_cur.wcount = cur.wcount + 32'h0000_0001;
                     if (cur.maint_cnt == nonvolatile_byte_store_pkg::MAINT_PERIOD - 8'h01) begin
                        next_cur.maint_cnt = 8'h00;
                     end else begin
                        next_cur.maint_cnt = cur.maint_cnt + 8'h01;
                     end
                     // Read-back check: an injected fault models a bad cell
                     if (cur.fault[nonvolatile_byte_store_pkg::FAULT_VERIFY_BIT]) begin
                        next_cur.corrupt[idx] = 1'b1;
                        next_cur.result0[nonvolatile_byte_store_pkg::WE_BIT] = 1'b1;
                     end else begin
                        next_cur.good[idx] = cur.wdata;
                        next_cur.corrupt[idx] = 1'b0;
                     end
                  end
               end else begin
                  next_cur.result1[nonvolatile_byte_store_pkg::FLASH_ERR_BIT] = flash_bad;
                  if (!addr_legal) begin
                     next_cur.result0 = nonvolatile_byte_store_pkg::ILLEGAL_READ_DATA;
                     next_cur.result1[nonvolatile_byte_store_pkg::ILLEGAL_ADDR_BIT] = 1'b1;
                  end else if (cur.corrupt[idx]) begin
                     next_cur.result0 = cur.good[idx];
                     next_cur.result1[nonvolatile_byte_store_pkg::DATA_ERR_BIT] = 1'b1;
                  end else begin
                     next_cur.result0 = cur.latest[idx];
                  end
               end
            end
         end
         default: begin
            next_cur.state = nonvolatile_byte_store_pkg::ST_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------
   // Results change only at completion, so caller context stays intact
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         cur <= '0;
         cur.state <= nonvolatile_byte_store_pkg::ST_IDLE;
         cur.ratio <= nonvolatile_byte_store_pkg::RATIO_RESET;
      end else begin
         cur <= next_cur;
      end
   end

endmodule

//--- include/nonvolatile_byte_store_pkg.sv
// Constants, register map and types of the non-volatile byte store
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package nonvolatile_byte_store_pkg;

   // ----------------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------------
   localparam int STORE_DEPTH = 64;
   localparam logic [7:0] MAINT_PERIOD = 8'd200;

   // ----------------------------------------------------------------------
   // Timing: figures in ns, counts in ref_clk cycles at 4 ns
   // ----------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 4;
   localparam int WRITE_TIME_NS = 136000;
   localparam int MAINT_TIME_NS = 58000000;
   localparam int ILL_WRITE_TIME_NS = 7000;
   localparam int READ_TIME_NS = 71000;
   localparam int ILL_READ_TIME_NS = 6000;
   localparam int WRITE_CYCLES = WRITE_TIME_NS / CLK_PERIOD_NS;
   localparam int MAINT_CYCLES = MAINT_TIME_NS / CLK_PERIOD_NS;
   localparam int READ_CYCLES = READ_TIME_NS / CLK_PERIOD_NS;
   localparam logic [31:0] ILL_WRITE_CYCLES = 32'(ILL_WRITE_TIME_NS / CLK_PERIOD_NS);
   localparam logic [31:0] ILL_READ_CYCLES = 32'(ILL_READ_TIME_NS / CLK_PERIOD_NS);

   // ----------------------------------------------------------------------
   // Register byte addresses
   // ----------------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_WDATA = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0C;
   localparam logic [7:0] REG_RESULT0 = 8'h10;
   localparam logic [7:0] REG_RESULT1 = 8'h14;
   localparam logic [7:0] REG_RATIO = 8'h18;
   localparam logic [7:0] REG_WCOUNT = 8'h1C;
   localparam logic [7:0] REG_FAULT = 8'h20;

   // ----------------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------------
   localparam int CTRL_WRITE_BIT = 0;
   localparam int CTRL_READ_BIT = 1;
   localparam int STATUS_BUSY_BIT = 0;
   localparam int STATUS_DONE_BIT = 1;
   localparam int WE_BIT = 0;
   localparam int ILLEGAL_ADDR_BIT = 1;
   localparam int FLASH_ERR_BIT = 2;
   localparam int DATA_ERR_BIT = 4;
   localparam int FAULT_VERIFY_BIT = 0;
   localparam int FAULT_FLASH_BIT = 1;
   localparam logic [15:0] RATIO_RESET = 16'h0001;
   localparam logic [7:0] ILLEGAL_READ_DATA = 8'hFF;

   // Operation sequencer
   typedef enum logic [0:0] {ST_IDLE, ST_BUSY} op_state_t;

endpackage

//--- tb/nonvolatile_byte_store_monitor.sv
// Port-level assertions for the non-volatile byte store
`timescale 1ns/1ns
module nonvolatile_byte_store_monitor (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Operation in progress
   input wire logic busy
);
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Start request in an access cycle
   wire logic start_acc = psel && penable && pwrite && paddr == nonvolatile_byte_store_pkg::REG_CTRL && |pwdata[1:0];
   // Read access cycle
   wire logic rd_acc = psel && penable && !pwrite;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   property p_start_busy; start_acc && !busy |-> ##[1:2] busy; endproperty
   property p_busy_cause; $rose(busy) |-> $past(start_acc) || $past(start_acc, 2); endproperty
   // Shortest operation still spans many cycles
   property p_busy_min; $rose(busy) |-> busy [*8]; endproperty
   property p_no_wait; psel && penable |-> pready; endproperty
   property p_err_unmapped; psel && !penable && paddr > nonvolatile_byte_store_pkg::REG_FAULT |=> pslverr; endproperty
   property p_err_mapped; psel && !penable && paddr[1:0] == 2'h0 && paddr <= nonvolatile_byte_store_pkg::REG_FAULT |=> !pslverr;
   endproperty
   property p_err_data; rd_acc && pslverr |-> prdata == 32'h0; endproperty
   property p_ctrl_read; rd_acc && paddr == nonvolatile_byte_store_pkg::REG_CTRL |-> prdata == 32'h0; endproperty
   // Busy flag seen by software matches the port
   property p_status_busy; rd_acc && paddr == nonvolatile_byte_store_pkg::REG_STATUS |-> prdata[0] == $past(busy) && prdata[31:2] == 30'h0;
   endproperty
   a_start_busy: assert property (p_start_busy) else $error("busy did not follow a start");
   a_busy_cause: assert property (p_busy_cause) else $error("busy rose without a start");
   a_busy_min: assert property (p_busy_min) else $error("operation ended too soon");
   a_no_wait: assert property (p_no_wait) else $error("pready low in access");
   a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not refused");
   a_err_mapped: assert property (p_err_mapped) else $error("mapped access refused");
   a_err_data: assert property (p_err_data) else $error("refused read returned data");
   a_ctrl_read: assert property (p_ctrl_read) else $error("control read not zero");
   a_status_busy: assert property (p_status_busy) else $error("status busy bit wrong");
   // Main scenarios reached
   c_done: cover property ($fell(busy));
   c_read_start: cover property (start_acc && pwdata[1:0] == 2'h2);
   c_refused: cover property (pslverr);
endmodule
bind nonvolatile_byte_store nonvolatile_byte_store_monitor mon (.ref_clk(ref_clk), .reset(reset), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .busy(busy));

//--- tb/caller_model.sv
// Model of the calling program: APB master issuing store requests
`timescale 1ns/1ns
module caller_model (
   // Clock
   input wire logic ref_clk,
   // APB master
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // Idle bus from time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end
   // One APB transfer, request held until pready
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd, output logic err);
      int n;
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 100);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Location first, then data, then start; arguments leave nothing behind
   task store_op(input logic wr, input logic [7:0] loc, input logic [7:0] val);
      logic [31:0] rd;
      logic err;
      apb(1'b1, nonvolatile_byte_store_pkg::REG_ADDR, {24'h0, loc}, rd, err);
      if (wr) begin
         apb(1'b1, nonvolatile_byte_store_pkg::REG_WDATA, {24'h0, val}, rd, err);
      end
      // Caller never interrupts: next request waits for idle
      apb(1'b1, nonvolatile_byte_store_pkg::REG_CTRL, wr ? 32'h1 : 32'h2, rd, err);
   endtask
endmodule

//--- tb/nonvolatile_byte_store_test.sv
// Self-checking bench for the non-volatile byte store
`timescale 1ns/1ns
module nonvolatile_byte_store_test;
   // Short counts keep the run brief
   localparam int WC = 20;
   localparam int MC = 50;
   localparam int RC = 10;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic psel, penable, pwrite, pready, pslverr, busy, e;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, r0, r1;
   int errors = 0;
   int checked = 0;
   int cycles = 0;
   int nw = 0;
   nonvolatile_byte_store #(.WRITE_CYCLES(WC), .MAINT_CYCLES(MC), .READ_CYCLES(RC), .STORE_SIZE(64)) DUT (
      .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy));
   caller_model host (.ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   initial forever #2 ref_clk = ~ref_clk;
   // Hang guard
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 60000) begin
         errors++;
         final_report();
      end
   end
   task final_report;
      $display("checks %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Duration with a few cycles of start and finish latency
   task check_time(input string what, input int exp, input int got);
      checked++;
      if (got < exp || got > exp + 4) begin
         errors++;
         $display("wrong value %s expected %0d seen %0d", what, exp, got);
      end
   endtask
   task rd(input logic [7:0] a, output logic [31:0] v);
      host.apb(1'b0, a, 32'h0, v, e);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      host.apb(1'b1, a, d, r0, e);
   endtask
   // One store operation; exp below zero skips the timing check
   task run(input logic w, input logic [7:0] a, input logic [7:0] d, input int exp);
      int n;
      host.store_op(w, a, d);
      n = 0;
      do begin
         @(negedge ref_clk);
         n++;
      end while (busy !== 1'b1 && n < 8);
      while (busy !== 1'b0 && n < 50000) begin
         @(negedge ref_clk);
         n++;
      end
      if (exp >= 0) check_time("duration", exp, n);
      rd(nonvolatile_byte_store_pkg::REG_RESULT0, r0);
      rd(nonvolatile_byte_store_pkg::REG_RESULT1, r1);
   endtask
   initial begin
      repeat (3) @(posedge ref_clk);
      reset <= 1'b0;
      rd(nonvolatile_byte_store_pkg::REG_STATUS, r0);
      check("status", 32'h0, r0);
      rd(nonvolatile_byte_store_pkg::REG_RATIO, r0);
      check("ratio", 32'h1, r0);
      rd(nonvolatile_byte_store_pkg::REG_WCOUNT, r0);
      check("wcount", 32'h0, r0);
      rd(8'h40, r0);
      check("unmapped", 32'h0, r0);
      check("pslverr", 32'h1, {31'h0, e});
      $display("test reset done");
      run(1'b1, 8'h00, 8'hA5, WC);
      nw++;
      check("wstatus", 32'h0, r0);
      run(1'b0, 8'h00, 8'h00, RC);
      check("rdata", 32'hA5, r0);
      check("rstatus", 32'h0, r1);
      $display("test basic done");
      run(1'b1, 8'h3F, 8'h5A, WC);
      nw++;
      run(1'b1, 8'h40, 8'hC3, 1750);
      check("wstatus", 32'h2, r0);
      run(1'b0, 8'h40, 8'h00, 1500);
      check("rdata", 32'hFF, r0);
      check("rstatus", 32'h2, r1);
      run(1'b0, 8'h3F, 8'h00, RC);
      check("rdata", 32'h5A, r0);
      $display("test range done");
      wr(nonvolatile_byte_store_pkg::REG_RATIO, 32'h3);
      run(1'b1, 8'h07, 8'h77, 3 * WC);
      nw++;
      wr(nonvolatile_byte_store_pkg::REG_RATIO, 32'h1);
      run(1'b1, 8'h05, 8'h11, WC);
      nw++;
      wr(nonvolatile_byte_store_pkg::REG_FAULT, 32'h1);
      run(1'b1, 8'h05, 8'h3C, WC);
      nw++;
      check("wstatus", 32'h1, r0);
      wr(nonvolatile_byte_store_pkg::REG_FAULT, 32'h0);
      run(1'b0, 8'h05, 8'h00, RC);
      check("rdata", 32'h11, r0);
      check("rstatus", 32'h10, r1);
      wr(nonvolatile_byte_store_pkg::REG_FAULT, 32'h2);
      run(1'b1, 8'h00, 8'h99, -1);
      check("wstatus", 32'h4, r0);
      wr(nonvolatile_byte_store_pkg::REG_FAULT, 32'h0);
      run(1'b0, 8'h00, 8'h00, RC);
      check("rdata", 32'hA5, r0);
      $display("test faults done");
      rd(nonvolatile_byte_store_pkg::REG_WCOUNT, r0);
      check("wcount", 32'(nw), r0);
      while (nw < 199) begin
         run(1'b1, 8'(nw % 64), 8'(nw), WC);
         nw++;
      end
      run(1'b1, 8'h01, 8'h42, WC + MC);
      check("wstatus", 32'h0, r0);
      $display("test maintenance done");
      final_report();
   end
endmodule
